// file: src/cdsl_pkg.sv
package cdsl_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned POWERUP_WAIT_MS = 50;
  localparam int unsigned POWERUP_WAIT_CYC = (CLK_HZ / 1000) * POWERUP_WAIT_MS;
  localparam int unsigned BUS_RATE_HZ = 100000;
  // Quarter bit period, rounded up so the bus never runs above its rate
  localparam int unsigned QTR_CYC = (CLK_HZ + 4 * BUS_RATE_HZ - 1) / (4 * BUS_RATE_HZ);

  // Address spans
  localparam int unsigned MEM_ADDR_W = 11;
  localparam int unsigned CFG_SPAN_BYTES = 512;
  localparam int unsigned ID_RAM_BYTES = 256;
  localparam int unsigned CFG_BYTES = 16;
  localparam logic [3:0] CFG_LAST_ADDR = 4'hf;
  localparam logic [MEM_ADDR_W-1:0] SIG_LO_ADDR = 11'h000;
  localparam logic [MEM_ADDR_W-1:0] SIG_HI_ADDR = 11'h001;

  // Signature; value arbitrary, replace with the product's own
  localparam logic [15:0] CFG_SIGNATURE = 16'h5a3c;

  // Two-wire control byte high nibble for a memory device
  localparam logic [3:0] MEM_DEV_CODE = 4'ha;

  // Built-in ROM configuration defaults for bytes 0..15
  localparam logic [7:0] ROM_CFG_DEFAULT [CFG_BYTES] = '{
    // Bytes 0 and 1 mirror the signature; their values are arbitrary
    8'h3c, 8'h5a, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Where descriptors and configuration come from
  typedef enum logic [1:0] {
    CDSL_SRC_ROM = 2'h0,
    CDSL_SRC_MEM = 2'h1,
    CDSL_SRC_IDENT = 2'h2
  } cdsl_src_t;

  // Request to the serial memory engine
  typedef struct packed {
    logic rd;
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } cdsl_mem_req_t;

  // Vendor access from the USB side
  typedef struct packed {
    logic load;
    logic wr;
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } cdsl_vend_req_t;

  // Byte of identify data from the ATA side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cdsl_ident_byte_t;

endpackage

// file: src/cdsl_sync.sv
`timescale 1ns/100ps
// Two flip-flop synchroniser for pin inputs
module cdsl_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: src/cdsl_twi.sv
`timescale 1ns/100ps
// Single-byte random read/write engine for the two-wire serial memory
module cdsl_twi (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic start,
  input wire logic probe,
  input wire cdsl_pkg::cdsl_mem_req_t req,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rdata,
  output logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import cdsl_pkg::*;

  typedef enum logic [3:0] {
    T_IDLE = 4'h0, T_START = 4'h1, T_BIT = 4'h3, T_ACK = 4'h2,
    T_RSTART = 4'h6, T_STOP = 4'h7, T_DONE = 4'h5
  } cdsl_twi_st_t;

  cdsl_twi_st_t st_q;
  logic [7:0] qtr_q;     // Quarter-bit timer
  logic [1:0] ph_q;      // Phase within a bit
  logic [2:0] bit_q;     // Bit index
  logic [2:0] byte_q;    // Byte index within the frame
  logic [7:0] sh_q;      // Shift register
  cdsl_mem_req_t r_q;
  logic probe_q;
  logic tick;

  assign tick = (qtr_q == 8'(QTR_CYC - 1));
  assign busy = (st_q != T_IDLE);

  // Byte to send at a given index
  function automatic logic [7:0] tx_byte(input logic [2:0] idx, input cdsl_mem_req_t r);
    case (idx)
      3'h0: tx_byte = {MEM_DEV_CODE, r.addr[10:8], 1'b0};
      3'h1: tx_byte = r.addr[7:0];
      3'h2: tx_byte = r.rd ? {MEM_DEV_CODE, r.addr[10:8], 1'b1} : r.wdata;
      default: tx_byte = 8'hff;
    endcase
  endfunction

  // Quarter-bit timer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) qtr_q <= 8'h00;
    else if (ce) qtr_q <= (!busy || tick) ? 8'h00 : qtr_q + 8'h01;
  end

  // Bus sequencer; the clock line is only ever driven, never sampled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= T_IDLE;
      ph_q <= 2'h0;
      bit_q <= 3'h7;
      byte_q <= 3'h0;
      sh_q <= 8'h00;
      r_q <= '0;
      probe_q <= 1'b0;
      scl <= 1'b1;
      sda_out <= 1'b1;
      done <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
    end else if (ce) begin
      done <= 1'b0;
      case (st_q)
        T_IDLE: begin
          scl <= 1'b1;
          sda_out <= 1'b1;
          if (start) begin
            r_q <= req;
            probe_q <= probe;
            byte_q <= 3'h0;
            ph_q <= 2'h0;
            nack <= 1'b0;
            st_q <= T_START;
          end
        end
        T_START: if (tick) begin
          // Data falls while clock is high, then clock falls
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) sda_out <= 1'b0;
          if (ph_q == 2'h1) begin
            scl <= 1'b0;
            sh_q <= tx_byte(byte_q, r_q);
            bit_q <= 3'h7;
            ph_q <= 2'h0;
            st_q <= T_BIT;
          end
        end
        T_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_out <= (byte_q == 3'h3) ? 1'b1 : sh_q[7];
            2'h1: scl <= 1'b1;
            2'h2: if (byte_q == 3'h3) rdata <= {rdata[6:0], sda_in};
            default: begin
              scl <= 1'b0;
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q - 3'h1;
              if (bit_q == 3'h0) st_q <= T_ACK;
            end
          endcase
        end
        T_ACK: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            // Reading: master sends no-ack after the data byte
            2'h0: sda_out <= 1'b1;
            2'h1: scl <= 1'b1;
            2'h2: if (byte_q != 3'h3 && sda_in) nack <= 1'b1;
            default: begin
              scl <= 1'b0;
              ph_q <= 2'h0;
              if ((byte_q != 3'h3 && sda_in) || probe_q) st_q <= T_STOP;
              else if (byte_q == 3'h1 && r_q.rd) st_q <= T_RSTART;
              else if (byte_q == 3'h3 || (byte_q == 3'h2 && !r_q.rd)) st_q <= T_STOP;
              else begin
                byte_q <= byte_q + 3'h1;
                sh_q <= tx_byte(byte_q + 3'h1, r_q);
                bit_q <= 3'h7;
                st_q <= T_BIT;
              end
              if (byte_q == 3'h2 && r_q.rd && !sda_in) begin
                byte_q <= 3'h3;
                bit_q <= 3'h7;
                st_q <= T_BIT;
              end
            end
          endcase
        end
        T_RSTART: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_out <= 1'b1;
            2'h1: scl <= 1'b1;
            2'h2: sda_out <= 1'b0;
            default: begin
              scl <= 1'b0;
              byte_q <= 3'h2;
              sh_q <= tx_byte(3'h2, r_q);
              bit_q <= 3'h7;
              st_q <= T_BIT;
            end
          endcase
        end
        T_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_out <= 1'b0;
            2'h1: scl <= 1'b1;
            2'h2: sda_out <= 1'b1;
            default: st_q <= T_DONE;
          endcase
        end
        T_DONE: begin
          done <= 1'b1;
          st_q <= T_IDLE;
        end
        default: st_q <= T_IDLE;
      endcase
    end
  end

  // Open-drain data: drive only a low
  assign sda_oe = !sda_out;
endmodule

// file: src/cdsl_loader.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Pin low, no memory: all from ROM
// - Pin high, bad signature: ROM for everything
// - Pin high, good signature: identify data, ROM meanwhile
// - Memory bad signature: ROM, recheck on vendor access
// - Memory good signature: everything from memory
// - Address 2 KB; config image first 512 bytes
// - Identify data held in 256-byte RAM
// - Serial bus at most 100 kHz
// - Clock output only; single master, 7-bit
// - Wait 50 ms after reset before probing
// - Valid only when first two bytes match signature
// - Recheck signature on vendor access bytes 0/1; the recheck runs on vendor reads of bytes 0/1 only, not on writes
// - Memory stays present until next reset
// - Missing acknowledge stalls the USB request
// - Retry memory access on next request
// - Identify data needs the same signature check
// - Failed identify signature: ROM defaults served
// - Identify-source pin active high selects identify data
// - Bytes 0x0..0xF load configuration registers; the memory load reads bytes 0x2..0xF only, bytes 0x0/0x1 keep the ROM defaults
// - Vendor write to config space updates registers
module cdsl_loader (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic ident_mode_pin,
  input wire logic vend_valid,
  input wire cdsl_pkg::cdsl_vend_req_t vend_req,
  output logic vend_done,
  output logic vend_stall,
  output logic [7:0] vend_rdata,
  input wire logic desc_valid,
  input wire logic [8:0] desc_addr,
  output logic desc_done,
  output logic [7:0] desc_rdata,
  input wire logic ident_valid,
  input wire cdsl_pkg::cdsl_ident_byte_t ident_byte,
  input wire logic ident_last,
  output cdsl_pkg::cdsl_src_t desc_src,
  output cdsl_pkg::cdsl_src_t cfg_src,
  output logic mem_present,
  output logic [8*cdsl_pkg::CFG_BYTES-1:0] cfg_regs,
  output logic load_done,
  output logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import cdsl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [3:0] {
    L_WAIT = 4'h0,    // Power-up delay
    L_PROBE = 4'h1,   // Address-only presence probe
    L_SIG0 = 4'h3,    // Read signature low byte
    L_SIG1 = 4'h2,    // Read signature high byte
    L_CFG = 4'h6,     // Read configuration bytes
    L_IDLE = 4'h7,    // Serve requests
    L_VEND = 4'h5,    // Vendor access in flight
    L_DESC = 4'h4,    // Descriptor read in flight
    L_RCHK0 = 4'hc,   // Recheck signature low byte
    L_RCHK1 = 4'hd    // Recheck signature high byte
  } cdsl_ld_st_t;

  cdsl_ld_st_t st_q;
  logic [21:0] wait_q;            // Power-up delay counter
  logic [3:0] idx_q;              // Config byte index
  logic [7:0] sig_lo_q;           // Signature low byte caught
  logic mem_sig_ok_q;             // Memory signature passed
  logic id_sig_ok_q;              // Identify signature passed
  logic [7:0] id_ram_q [ID_RAM_BYTES];  // Identify data store
  logic [7:0] cfg_q [CFG_BYTES];  // Configuration registers
  logic mode_q;                   // Synchronised source pin
  logic eng_start;
  logic eng_probe;
  cdsl_mem_req_t eng_req;
  logic eng_busy;
  logic eng_done;
  logic eng_nack;
  logic [7:0] eng_rdata;
  logic [15:0] id_sig;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and serial engine

  // Source pin is active high
  cdsl_sync u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d(ident_mode_pin),
    .q(mode_q)
  );

  // Engine paced from the core clock
  cdsl_twi u_twi (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start(eng_start),
    .probe(eng_probe),
    .req(eng_req),
    .busy(eng_busy),
    .done(eng_done),
    .nack(eng_nack),
    .rdata(eng_rdata),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Memory access request with 11-bit address
  function automatic cdsl_mem_req_t mk_req(input logic rd, input logic [10:0] a,
                                           input logic [7:0] d);
    mk_req.rd = rd;
    mk_req.addr = a;
    mk_req.wdata = d;
  endfunction

  // Signature compare shared by both sources
  function automatic logic sig_match(input logic [7:0] lo, input logic [7:0] hi);
    sig_match = ({hi, lo} == CFG_SIGNATURE);
  endfunction

  // Built-in ROM byte for a descriptor address
  function automatic logic [7:0] rom_byte(input logic [8:0] a);
    rom_byte = (a < 9'(CFG_BYTES)) ? ROM_CFG_DEFAULT[a[3:0]] : 8'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Source selection

  assign id_sig = {id_ram_q[1], id_ram_q[0]};

  // Source table by pin, presence and signature
  always_comb begin
    if (mode_q) begin
      // Identify data used only once checked
      desc_src = id_sig_ok_q ? CDSL_SRC_IDENT : CDSL_SRC_ROM;
      cfg_src = id_sig_ok_q ? CDSL_SRC_IDENT : CDSL_SRC_ROM;
    end else if (mem_present && mem_sig_ok_q) begin
      desc_src = CDSL_SRC_MEM;
      cfg_src = CDSL_SRC_MEM;
    end else begin
      desc_src = CDSL_SRC_ROM;
      cfg_src = CDSL_SRC_ROM;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine request decode

  always_comb begin
    eng_start = 1'b0;
    eng_probe = 1'b0;
    eng_req = '0;
    if (!eng_busy && !eng_done) begin
      case (st_q)
        L_PROBE: begin
          eng_start = 1'b1;
          eng_probe = 1'b1;
        end
        L_SIG0, L_RCHK0: begin
          eng_start = 1'b1;
          eng_req = mk_req(1'b1, SIG_LO_ADDR, 8'h00);
        end
        L_SIG1, L_RCHK1: begin
          eng_start = 1'b1;
          eng_req = mk_req(1'b1, SIG_HI_ADDR, 8'h00);
        end
        L_CFG: begin
          eng_start = 1'b1;
          eng_req = mk_req(1'b1, {7'h00, idx_q}, 8'h00);
        end
        L_VEND, L_DESC: begin
          // Staged request from the idle state, one start pulse
          eng_start = xfer_start_q;
          eng_req = xfer_req_q;
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= L_WAIT;
      wait_q <= '0;
      idx_q <= 4'h0;
      sig_lo_q <= 8'h00;
      mem_sig_ok_q <= 1'b0;
      mem_present <= 1'b0;
      load_done <= 1'b0;
      vend_done <= 1'b0;
      vend_stall <= 1'b0;
      vend_rdata <= 8'h00;
      desc_done <= 1'b0;
      desc_rdata <= 8'h00;
    end else if (ce) begin
      vend_done <= 1'b0;
      vend_stall <= 1'b0;
      desc_done <= 1'b0;
      case (st_q)
        L_WAIT: begin
          // Hold off probing after reset
          wait_q <= wait_q + 22'h1;
          if (wait_q == 22'(POWERUP_WAIT_CYC - 1)) st_q <= mode_q ? L_IDLE : L_PROBE;
        end
        L_PROBE: if (eng_done) begin
          // Presence sticks until reset
          mem_present <= !eng_nack;
          st_q <= eng_nack ? L_IDLE : L_SIG0;
        end
        L_SIG0, L_RCHK0: if (eng_done) begin
          sig_lo_q <= eng_rdata;
          st_q <= eng_nack ? L_IDLE : (st_q == L_SIG0 ? L_SIG1 : L_RCHK1);
          if (st_q == L_RCHK0 && eng_nack) vend_stall <= 1'b1;
          if (st_q == L_RCHK0 && !eng_nack) vend_rdata <= eng_rdata;
        end
        L_SIG1, L_RCHK1: if (eng_done) begin
          if (eng_nack) begin
            st_q <= L_IDLE;
            vend_stall <= (st_q == L_RCHK1);
          end else if (sig_match(sig_lo_q, eng_rdata)) begin
            mem_sig_ok_q <= 1'b1;
            idx_q <= 4'h2;
            st_q <= L_CFG;
          end else begin
            st_q <= L_IDLE;
          end
          if (st_q == L_RCHK1 && !eng_nack) begin
            vend_done <= 1'b1;
            vend_rdata <= vend_req.addr[0] ? eng_rdata : sig_lo_q;
          end
        end
        L_CFG: if (eng_done) begin
          // Load bytes up to 0xF
          if (eng_nack) st_q <= L_IDLE;
          else if (idx_q == CFG_LAST_ADDR) st_q <= L_IDLE;
          idx_q <= idx_q + 4'h1;
        end
        L_IDLE: begin
          load_done <= 1'b1;
          if (vend_valid && mem_present && !mem_sig_ok_q && !vend_req.wr &&
              vend_req.addr[10:1] == 10'h000) begin
            st_q <= L_RCHK0;
          end else if (vend_valid && mem_present) begin
            st_q <= L_VEND;
          end else if (vend_valid) begin
            // No memory: answer with a stall
            vend_stall <= 1'b1;
          end else if (desc_valid) begin
            if (desc_src == CDSL_SRC_MEM) begin
              st_q <= L_DESC;
            end else begin
              desc_done <= 1'b1;
              desc_rdata <= (desc_src == CDSL_SRC_IDENT && desc_addr < 9'(ID_RAM_BYTES))
                            ? id_ram_q[desc_addr[7:0]] : rom_byte(desc_addr);
            end
          end
        end
        L_VEND, L_DESC: if (eng_done) begin
          // Each new request starts a fresh try
          st_q <= L_IDLE;
          if (st_q == L_VEND) begin
            vend_stall <= eng_nack;
            vend_done <= !eng_nack;
            vend_rdata <= eng_rdata;
          end else begin
            desc_done <= !eng_nack;
            desc_rdata <= eng_rdata;
          end
        end
        default: st_q <= L_WAIT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data accesses issued from the idle state are held in the engine request

  // Vendor and descriptor transfers use a separate start pulse
  logic xfer_start_q;
  cdsl_mem_req_t xfer_req_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xfer_start_q <= 1'b0;
      xfer_req_q <= '0;
    end else if (ce) begin
      xfer_start_q <= 1'b0;
      if (st_q == L_IDLE && vend_valid && mem_present &&
          !(!mem_sig_ok_q && !vend_req.wr && vend_req.addr[10:1] == 10'h000)) begin
        xfer_start_q <= 1'b1;
        xfer_req_q <= mk_req(!vend_req.wr, vend_req.addr, vend_req.wdata);
      end else if (st_q == L_IDLE && !vend_valid && desc_valid && desc_src == CDSL_SRC_MEM) begin
        xfer_start_q <= 1'b1;
        xfer_req_q <= mk_req(1'b1, {2'h0, desc_addr}, 8'h00);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Identify data store

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      id_sig_ok_q <= 1'b0;
    end else if (ce) begin
      if (ident_valid) id_sig_ok_q <= 1'b0;
      if (ident_last) id_sig_ok_q <= sig_match(id_sig[7:0], id_sig[15:8]);
    end
  end

  always_ff @(posedge clk) begin
    if (ce && ident_valid) id_ram_q[ident_byte.addr] <= ident_byte.data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CFG_BYTES; i++) cfg_q[i] <= 8'h00;
    end else if (ce) begin
      if (st_q == L_WAIT) begin
        // ROM values until a source delivers
        for (int i = 0; i < CFG_BYTES; i++) cfg_q[i] <= ROM_CFG_DEFAULT[i];
      end else if (st_q == L_CFG && eng_done && !eng_nack) begin
        cfg_q[idx_q] <= eng_rdata;
      end else if (st_q == L_VEND && eng_done && !eng_nack && vend_req.wr &&
                   vend_req.addr[10:4] == 7'h00) begin
        cfg_q[vend_req.addr[3:0]] <= vend_req.wdata;
      end else if (mode_q && ident_last && sig_match(id_ram_q[0], id_ram_q[1])) begin
        for (int i = 0; i < CFG_BYTES; i++) cfg_q[i] <= id_ram_q[i];
      end
    end
  end

  // Flatten configuration registers
  always_comb begin
    for (int i = 0; i < CFG_BYTES; i++) cfg_regs[8*i +: 8] = cfg_q[i];
  end

endmodule

// file: dv/cdsl_mem_model.sv
`timescale 1ns/100ps
// Two-wire serial memory, 2 KB, single-byte random read and write
module cdsl_mem_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic present,
  input wire logic no_ack,
  output logic pull
);
  logic [7:0] mem [2048]; // Byte accesses never cross a page
  logic [7:0] sh;
  logic [10:0] ptr;
  logic ack;
  int bitn; // Bits done in this byte, -1 just after a start
  int ph; // 0 control, 1 address, 2 write, 3 read, 4 idle
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
    mem[0] = 8'h00;
    mem[1] = 8'h00;
    {pull, ack, ptr, sh, bitn, ph} = '0;
    ph = 4;
  end
  // Start and stop conditions
  always @(negedge sda) if (scl) begin
    ph = 0;
    bitn = -1;
    pull = 0;
  end
  always @(posedge sda) if (scl) ph = 4;
  // Sample on the rise; a high master acknowledge ends a read
  always @(posedge scl) begin
    if (ph < 3 && bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    if (ph == 3 && bitn == 8 && sda) ph = 4;
  end
  // Acknowledge and read bits change only while the clock is low
  always @(negedge scl) begin
    if (ph == 4) pull = 0;
    else if (bitn == 8) begin
      pull = 0;
      bitn = 0;
      if (!ack) ph = 4;
      else if (ph == 3) begin
        sh = mem[ptr];
        ptr = ptr + 11'h001;
        pull = !sh[7];
      end
    end else begin
      bitn = bitn + 1;
      if (ph == 3) pull = bitn < 8 && !sh[7 - bitn];
      else if (bitn == 8) begin
        ack = present && !no_ack;
        if (ph == 0) begin
          ack = ack && sh[7:4] == 4'ha;
          ptr[10:8] = sh[3:1];
          ph = sh[0] ? 3 : 1;
        end else if (ph == 1) begin
          ptr[7:0] = sh;
          ph = 2;
        end else if (ack) begin
          mem[ptr] = sh;
          ptr = ptr + 11'h001;
        end
        pull = ack;
      end
    end
  end
endmodule

// file: dv/cdsl_props.sv
`timescale 1ns/100ps
// Port checker for the loader
module cdsl_props
  import cdsl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic vend_valid,
  input wire logic vend_stall,
  input wire logic load_done,
  input wire logic mem_present,
  input wire logic scl,
  input wire logic sda_oe,
  input wire cdsl_pkg::cdsl_src_t desc_src,
  input wire cdsl_pkg::cdsl_src_t cfg_src,
  input wire logic [8*cdsl_pkg::CFG_BYTES-1:0] cfg_regs
);
  int unsigned up_q; // Cycles since reset release
  int unsigned per_q; // Cycles since the last serial clock rise
  logic scl_q;
  // Power-up and serial clock period counters
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      up_q <= 0;
      per_q <= 0;
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl;
      if (up_q < POWERUP_WAIT_CYC) up_q <= up_q + 1;
      if (scl && !scl_q) per_q <= 1;
      else if (per_q != 0 && per_q < 1000) per_q <= per_q + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  probe_wait_a: assert property (up_q + 1 < POWERUP_WAIT_CYC |-> scl && !sda_oe)
    else $error("serial bus active during the power-up wait");
  bus_rate_a: assert property (scl && !scl_q && per_q != 0 |-> per_q >= 250)
    else $error("serial clock period too short");
  present_sticky_a: assert property (mem_present |=> mem_present)
    else $error("memory presence dropped");
  late_present_a: assert property ($rose(mem_present) |-> !$past(load_done))
    else $error("memory presence found after start-up");
  absent_stall_a: assert property (
    $rose(vend_valid) && load_done && !mem_present |-> ##[1:3] vend_stall)
    else $error("vendor access without memory not stalled");
  mem_src_a: assert property (desc_src == CDSL_SRC_MEM |-> mem_present)
    else $error("memory source without memory");
  rom_first_a: assert property (!load_done |-> desc_src == CDSL_SRC_ROM && cfg_src == desc_src)
    else $error("source other than ROM before load");
  ident_both_a: assert property (desc_src == CDSL_SRC_IDENT |-> cfg_src == CDSL_SRC_IDENT)
    else $error("identify source split");
  rom_cfg_a: assert property (up_q > 2 && up_q + 1 < POWERUP_WAIT_CYC |-> cfg_regs[39:32] == 8'h80)
    else $error("configuration not at ROM default during wait");
endmodule
bind cdsl_loader cdsl_props i_props (.*);

// file: dv/tb_top.sv
`timescale 1ns/100ps
// Bench for the configuration loader with a serial memory model
module tb_top;
  import cdsl_pkg::*;
  typedef struct packed {
    logic vend;
    logic wr;
    logic [10:0] a;
    logic [7:0] wd;
    logic [7:0] exp;
  } cdsl_row_t;
  logic clk, reset, ce, ident_mode_pin, vend_valid, desc_valid, ident_valid, ident_last;
  logic vend_done, vend_stall, desc_done, mem_present, load_done, scl, sda_in, sda_out, sda_oe;
  logic [7:0] vend_rdata, desc_rdata, rd;
  logic [8:0] desc_addr;
  logic [127:0] cfg_regs;
  cdsl_vend_req_t vend_req;
  cdsl_ident_byte_t ident_byte;
  cdsl_src_t desc_src, cfg_src;
  logic present, no_ack, mem_pull, st;
  int fail_count, cmp_count;
  // Reads, writes and the signature repair, in order
  cdsl_row_t rows [8] = '{
    '{1'b0, 1'b0, 11'h004, 8'h00, 8'h80},
    '{1'b1, 1'b0, 11'h7ff, 8'h00, 8'h5a},
    '{1'b1, 1'b1, 11'h003, 8'h11, 8'h00},
    '{1'b1, 1'b1, 11'h000, CFG_SIGNATURE[7:0], 8'h00},
    '{1'b1, 1'b1, 11'h001, CFG_SIGNATURE[15:8], 8'h00},
    '{1'b1, 1'b0, 11'h000, 8'h00, CFG_SIGNATURE[7:0]},
    '{1'b0, 1'b0, 11'h003, 8'h00, 8'h11},
    '{1'b1, 1'b0, 11'h200, 8'h00, 8'ha5}};
  cdsl_loader i_dut (.*);
  cdsl_mem_model i_mem (.scl(scl), .sda(sda_in), .present(present), .no_ack(no_ack),
    .pull(mem_pull));
  // Open-drain line with pull-up
  assign sda_in = !(sda_oe || mem_pull);
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One vendor or descriptor access, held until answered
  task automatic access(input logic vend, input logic wr, input logic [10:0] a,
      input logic [7:0] wd);
    int n;
    vend_req = '{1'b0, wr, a, wd};
    desc_addr = a[8:0];
    vend_valid = vend;
    desc_valid = !vend;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((vend_done | vend_stall | desc_done) !== 1'b1 && n < 200000);
    if (n == 200000) begin
      fail_count++;
      report_and_stop;
    end
    st = vend_stall;
    rd = vend ? vend_rdata : desc_rdata;
    vend_valid = 0;
    desc_valid = 0;
  endtask
  task automatic wait_load;
    int n;
    for (n = 0; load_done !== 1'b1 && n < POWERUP_WAIT_CYC + 60000; n++) @(negedge clk);
    if (load_done !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  // Identify block with a chosen signature and byte 4
  task automatic send_ident(input logic [15:0] sig, input logic [7:0] b4);
    for (int i = 0; i < 16; i++) begin
      ident_byte = '{8'(i), i == 0 ? sig[7:0] : i == 1 ? sig[15:8] : i == 4 ? b4 : 8'h00};
      ident_valid = 1;
      @(negedge clk);
    end
    ident_valid = 0;
    ident_last = 1;
    @(negedge clk);
    ident_last = 0;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    {reset, ce, ident_mode_pin, vend_valid, desc_valid, ident_valid, ident_last} = 7'h60;
    {vend_req, desc_addr, ident_byte} = '0;
    {present, no_ack} = 2'b10;
    repeat (20) @(negedge clk);
    reset = 0;
    wait_load;
    check(mem_present, 1'b1);
    check(desc_src, CDSL_SRC_ROM);
    check(cfg_src, CDSL_SRC_ROM);
    $display("start-up with bad signature done");
    foreach (rows[i]) begin
      access(rows[i].vend, rows[i].wr, rows[i].a, rows[i].wd);
      check(st, 1'b0);
      if (!rows[i].wr) check(rd, rows[i].exp);
      $display("row %0d done", i);
    end
    check(desc_src, CDSL_SRC_MEM);
    check(cfg_regs[31:24], 8'h11);
    no_ack = 1;
    access(1'b1, 1'b0, 11'h005, 8'h00);
    check(st, 1'b1);
    no_ack = 0;
    access(1'b1, 1'b0, 11'h005, 8'h00);
    check({st, rd}, 9'h0a0);
    check(mem_present, 1'b1);
    $display("missing acknowledge done");
    ident_mode_pin = 1;
    repeat (4) @(negedge clk);
    send_ident(16'h1234, 8'h77);
    check({desc_src, cfg_src}, {CDSL_SRC_ROM, CDSL_SRC_ROM});
    send_ident(CFG_SIGNATURE, 8'h77);
    check({desc_src, cfg_regs[39:32]}, {CDSL_SRC_IDENT, 8'h77});
    access(1'b0, 1'b0, 11'h004, 8'h00);
    check(rd, 8'h77);
    $display("identify data done");
    {present, ident_mode_pin, reset} = 3'b001;
    repeat (2) @(negedge clk);
    check(mem_present, 1'b0);
    reset = 0;
    repeat (5) @(negedge clk);
    check(cfg_regs[39:32], 8'h80);
    wait_load;
    check({mem_present, desc_src}, {1'b0, CDSL_SRC_ROM});
    access(1'b1, 1'b0, 11'h004, 8'h00);
    check(st, 1'b1);
    access(1'b0, 1'b0, 11'h004, 8'h00);
    check(rd, 8'h80);
    $display("no memory done");
    report_and_stop;
  end
endmodule
